/* File: include/ssp_pkg.sv */
package ssp_pkg;

	// pin positions within the six-pin group
	localparam int NUM_PINS = 6;
	localparam int PIN_CTRL0 = 0;
	localparam int PIN_CTRL1 = 1;
	localparam int PIN_FSYNC = 2;
	localparam int PIN_BCLK = 3;
	localparam int PIN_RXD = 4;
	localparam int PIN_TXD = 5;

	// serial word and transmitter lanes (lane 0 on tx data, 1 and 2 on control lines)
	localparam int WORD_LEN = 16;
	localparam int NUM_LANES = 3;
	localparam int LANE_TX1 = 1;
	localparam int LANE_TX2 = 2;

	// reset state of the pins: general-purpose inputs, nothing driven
	localparam logic [5:0] PIN_OE_RST = 6'h00;
	localparam logic [5:0] PIN_OUT_RST = 6'h00;

	// timing: external bit clock period of at least 6 system phases, two phases a cycle
	localparam int CLK_PERIOD_NS = 50;
	localparam int BIT_CLK_MIN_PERIOD_PH = 6;
	localparam int PHASES_PER_CYCLE = 2;
	localparam int BIT_CLK_MIN_CYC =
		(BIT_CLK_MIN_PERIOD_PH + PHASES_PER_CYCLE - 1) / PHASES_PER_CYCLE;
	localparam int BIT_CLK_MIN_PERIOD_NS = BIT_CLK_MIN_CYC * CLK_PERIOD_NS;
	// internal bit clock: each half lasts at least the minimum cycle count
	localparam int BCLK_HALF_CYC = BIT_CLK_MIN_CYC;

	// static configuration of the serial function
	typedef struct packed {
		logic async_mode;
		logic bitclk_out;
		logic fsync_out;
		logic rxclk_out;
		logic rxfs_out;
		logic flag_mode;
		logic [1:0] flag_is_out;
		logic [1:0] flag_out;
		logic tx_en;
		logic rx_en;
	} ssp_cfg_t;

	// pin drive: level and output enable per pin
	typedef struct packed {
		logic [NUM_PINS-1:0] o;
		logic [NUM_PINS-1:0] oe;
	} ssp_pins_t;

	// bits produced on the link clock for the pins
	typedef struct packed {
		logic fs;
		logic [NUM_LANES-1:0] tx;
	} ssp_lane_t;

endpackage

/* File: rtl/ssp_sync.sv */
`timescale 1ns/10ps
module ssp_sync #(
	parameter int W = 1
) (
	// clock and reset
	input clk,
	input reset_n,
	// level in and synchronised level out
	input [W-1:0] d,
	output [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ssp_sync_st_t;

	ssp_sync_st_t st_ff;
	ssp_sync_st_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign q = st_ff.s2;

endmodule // ssp_sync

/* File: rtl/ssp_link.sv */
`timescale 1ns/10ps
module ssp_link #(
	parameter int W = ssp_pkg::WORD_LEN
) (
	// link clock and reset
	input link_clk,
	input reset_n,
	// configuration levels from the system domain
	input cfg_async,
	input cfg_fs_out,
	input cfg_tx_en,
	input cfg_rx_en,
	// transmit handshake from the system domain
	input req_tgl,
	input [ssp_pkg::NUM_LANES-1:0][W-1:0] tx_words,
	output ack_tgl,
	// pins, synchronous to the link clock
	input fs_pin,
	input rxd_pin,
	// link-side outputs
	output ssp_pkg::ssp_lane_t lane,
	output rx_tgl,
	output [W-1:0] rx_hold
);

	localparam int CW = $clog2(W);
	localparam logic [CW-1:0] LAST = CW'(W - 1);

	typedef struct packed {
		logic [ssp_pkg::NUM_LANES-1:0][W-1:0] tx_sh;
		logic [W-1:0] rx_sh;
		logic [W-1:0] rx_hold;
		logic [CW-1:0] cnt;
		logic fs;
		logic ack;
		logic rx_tgl;
	} ssp_link_st_t;

	ssp_link_st_t st_ff;
	ssp_link_st_t nxt_st;
	logic [4:0] cfg_s;
	logic start;
	logic [CW-1:0] idx;
	logic [W-1:0] rx_next;

	ssp_sync #(.W(5)) u_cfg_sync (
		.clk(link_clk),
		.reset_n(reset_n),
		.d({req_tgl, cfg_async, cfg_fs_out, cfg_tx_en, cfg_rx_en}),
		.q(cfg_s)
	);

	always_comb
	begin
		nxt_st = st_ff;
		// frame start from own counter or from the partner's frame sync
		start = cfg_s[2] ? (st_ff.cnt == '0) : fs_pin;
		idx = start ? '0 : st_ff.cnt;
		nxt_st.cnt = (idx == LAST) ? '0 : CW'(idx + 1'b1);
		nxt_st.fs = cfg_s[2] && (idx == LAST);
		// transmitters are clocked by the bit clock in every mode
		if (idx == LAST)
		begin
			nxt_st.tx_sh = '0;
			if (cfg_s[1] && (cfg_s[4] != st_ff.ack))
			begin
				nxt_st.tx_sh = tx_words;
				nxt_st.ack = ~st_ff.ack;
			end
		end
		else
		begin
			for (int i = 0; i < ssp_pkg::NUM_LANES; i++)
				nxt_st.tx_sh[i] = {st_ff.tx_sh[i][W-2:0], 1'b0};
		end
		// receiver uses the bit clock only in synchronous mode
		rx_next = {st_ff.rx_sh[W-2:0], rxd_pin};
		if (cfg_s[0] && !cfg_s[3])
		begin
			nxt_st.rx_sh = rx_next;
			if (idx == LAST)
			begin
				nxt_st.rx_hold = rx_next;
				nxt_st.rx_tgl = ~st_ff.rx_tgl;
			end
		end
	end

	always_ff @(posedge link_clk or negedge reset_n)
	begin
		if (!reset_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	always_comb
	begin
		lane.fs = st_ff.fs;
		for (int i = 0; i < ssp_pkg::NUM_LANES; i++)
			lane.tx[i] = st_ff.tx_sh[i][W-1];
	end

	assign ack_tgl = st_ff.ack;
	assign rx_tgl = st_ff.rx_tgl;
	assign rx_hold = st_ff.rx_hold;

endmodule // ssp_link

/* File: rtl/ssp_top.sv */
`timescale 1ns/10ps
module ssp_top #(
	parameter int W = ssp_pkg::WORD_LEN,
	parameter int BCLK_HALF = ssp_pkg::BCLK_HALF_CYC
) (
	// clocks and reset
	input clk,
	input reset_n,
	input link_clk,
	// configuration levels
	input ssp_pkg::ssp_cfg_t cfg,
	input [ssp_pkg::NUM_PINS-1:0] port_ctrl,
	input [ssp_pkg::NUM_PINS-1:0] port_dir,
	input stop_mode,
	// general-purpose port data
	input [ssp_pkg::NUM_PINS-1:0] gpio_out,
	output [ssp_pkg::NUM_PINS-1:0] gpio_in,
	// serial flags read back
	output [1:0] flag_in,
	// transmit words
	input [ssp_pkg::NUM_LANES-1:0][W-1:0] tx_words,
	input tx_valid,
	output tx_ready,
	// receive words
	output [W-1:0] rx_word,
	output rx_valid,
	// pins
	input [ssp_pkg::NUM_PINS-1:0] pin_in,
	output ssp_pkg::ssp_pins_t pin_drive
);

	localparam int CW = $clog2(W);
	localparam logic [CW-1:0] LAST = CW'(W - 1);
	localparam int DW = $clog2(BCLK_HALF + 1);
	localparam logic [DW-1:0] HALF_LAST = DW'(BCLK_HALF - 1);

	typedef struct packed {
		ssp_pkg::ssp_pins_t pins;
		logic [ssp_pkg::NUM_PINS-1:0] gpio_in;
		logic [1:0] flag_in;
		logic [ssp_pkg::NUM_LANES-1:0][W-1:0] tx_hold;
		logic req;
		logic tx_ready;
		logic [W-1:0] rx_word;
		logic rx_valid;
		logic rx_seen;
		logic bclk;
		logic [DW-1:0] bclk_cnt;
		logic arx_clk_prev;
		logic [W-1:0] arx_sh;
		logic [CW-1:0] arx_cnt;
		logic arx_fs;
	} ssp_top_st_t;

	ssp_top_st_t st_ff;
	ssp_top_st_t nxt_st;

	logic [ssp_pkg::NUM_PINS-1:0] pin_s;
	ssp_pkg::ssp_lane_t lane_l;
	logic [3:0] lane_s;
	logic ack_l;
	logic rx_tgl_l;
	logic [1:0] hs_s;
	logic [W-1:0] rx_hold_l;

	logic [ssp_pkg::NUM_PINS-1:0] ser_o;
	logic [ssp_pkg::NUM_PINS-1:0] ser_oe;
	logic arx_clk;
	logic arx_rise;
	logic arx_start;
	logic [CW-1:0] arx_idx;
	logic [W-1:0] arx_next;
	logic bclk_run;

	// every pin level passes two flops before system-clock logic reads it; the link reads frame sync and receive data directly
	ssp_sync #(.W(ssp_pkg::NUM_PINS)) u_pin_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d(pin_in),
		.q(pin_s)
	);

	// link-clock bits headed for the pins
	ssp_sync #(.W(4)) u_lane_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d(lane_l),
		.q(lane_s)
	);

	// handshake toggles coming back from the link domain
	ssp_sync #(.W(2)) u_hs_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d({ack_l, rx_tgl_l}),
		.q(hs_s)
	);

	ssp_link #(.W(W)) u_link (
		.link_clk(link_clk),
		.reset_n(reset_n),
		.cfg_async(cfg.async_mode),
		.cfg_fs_out(cfg.fsync_out),
		.cfg_tx_en(cfg.tx_en),
		.cfg_rx_en(cfg.rx_en),
		.req_tgl(st_ff.req),
		.tx_words(st_ff.tx_hold),
		.ack_tgl(ack_l),
		.fs_pin(pin_in[ssp_pkg::PIN_FSYNC]),
		.rxd_pin(pin_in[ssp_pkg::PIN_RXD]),
		.lane(lane_l),
		.rx_tgl(rx_tgl_l),
		.rx_hold(rx_hold_l)
	);

	// serial function of each pin
	always_comb
	begin
		ser_o = '0;
		ser_oe = '0;
		if (cfg.async_mode)
		begin
			ser_oe[ssp_pkg::PIN_CTRL0] = cfg.rxclk_out;
			ser_o[ssp_pkg::PIN_CTRL0] = st_ff.bclk;
			ser_oe[ssp_pkg::PIN_CTRL1] = cfg.rxfs_out;
			ser_o[ssp_pkg::PIN_CTRL1] = st_ff.arx_fs;
		end
		else if (cfg.flag_mode)
		begin
			ser_oe[ssp_pkg::PIN_CTRL0] = cfg.flag_is_out[0];
			ser_o[ssp_pkg::PIN_CTRL0] = cfg.flag_out[0];
			ser_oe[ssp_pkg::PIN_CTRL1] = cfg.flag_is_out[1];
			ser_o[ssp_pkg::PIN_CTRL1] = cfg.flag_out[1];
		end
		else
		begin
			ser_oe[ssp_pkg::PIN_CTRL0] = cfg.tx_en;
			ser_o[ssp_pkg::PIN_CTRL0] = lane_s[ssp_pkg::LANE_TX1];
			ser_oe[ssp_pkg::PIN_CTRL1] = cfg.tx_en;
			ser_o[ssp_pkg::PIN_CTRL1] = lane_s[ssp_pkg::LANE_TX2];
		end
		ser_oe[ssp_pkg::PIN_FSYNC] = cfg.fsync_out;
		ser_o[ssp_pkg::PIN_FSYNC] = lane_s[3];
		ser_oe[ssp_pkg::PIN_BCLK] = cfg.bitclk_out;
		ser_o[ssp_pkg::PIN_BCLK] = st_ff.bclk;
		ser_oe[ssp_pkg::PIN_RXD] = 1'b0;
		ser_o[ssp_pkg::PIN_RXD] = 1'b0;
		ser_oe[ssp_pkg::PIN_TXD] = cfg.tx_en;
		ser_o[ssp_pkg::PIN_TXD] = lane_s[0];
	end

	// asynchronous receiver: clock on control line zero, frame on control line one
	always_comb
	begin
		arx_clk = cfg.rxclk_out ? st_ff.bclk : pin_s[ssp_pkg::PIN_CTRL0];
		arx_rise = arx_clk && !st_ff.arx_clk_prev;
		arx_start = cfg.rxfs_out ? (st_ff.arx_cnt == '0) : pin_s[ssp_pkg::PIN_CTRL1];
		arx_idx = arx_start ? '0 : st_ff.arx_cnt;
		arx_next = {st_ff.arx_sh[W-2:0], pin_s[ssp_pkg::PIN_RXD]};
		bclk_run = cfg.bitclk_out || (cfg.async_mode && cfg.rxclk_out);
	end

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.rx_valid = 1'b0;

		// internal bit clock, never faster than the minimum period
		if (bclk_run)
		begin
			if (st_ff.bclk_cnt == HALF_LAST)
			begin
				nxt_st.bclk_cnt = '0;
				nxt_st.bclk = ~st_ff.bclk;
			end
			else
				nxt_st.bclk_cnt = DW'(st_ff.bclk_cnt + 1'b1);
		end
		else
		begin
			nxt_st.bclk_cnt = '0;
			nxt_st.bclk = 1'b0;
		end

		// transmit word handoff to the link domain
		if (tx_valid && st_ff.tx_ready)
		begin
			nxt_st.tx_hold = tx_words;
			nxt_st.req = ~st_ff.req;
			nxt_st.tx_ready = 1'b0;
		end
		else
			nxt_st.tx_ready = (hs_s[1] == st_ff.req);

		if (stop_mode)
		begin
			// keep levels, float every driver, freeze pin samples; the transmit handoff still runs
			nxt_st.pins.oe = '0;
		end
		else
		begin
			// pin mux: general-purpose unless the control bit selects serial
			for (int i = 0; i < ssp_pkg::NUM_PINS; i++)
			begin
				if (port_ctrl[i])
				begin
					nxt_st.pins.o[i] = ser_o[i];
					nxt_st.pins.oe[i] = ser_oe[i];
				end
				else
				begin
					nxt_st.pins.o[i] = gpio_out[i];
					nxt_st.pins.oe[i] = port_dir[i];
				end
			end
			nxt_st.gpio_in = pin_s;
			if (!cfg.async_mode && cfg.flag_mode)
				nxt_st.flag_in = pin_s[1:0];

			// synchronous receive word arrives from the link domain
			nxt_st.rx_seen = hs_s[0];
			if (hs_s[0] != st_ff.rx_seen)
			begin
				nxt_st.rx_word = rx_hold_l;
				nxt_st.rx_valid = 1'b1;
			end

			nxt_st.arx_clk_prev = arx_clk;
			if (cfg.async_mode && cfg.rx_en && arx_rise)
			begin
				nxt_st.arx_sh = arx_next;
				nxt_st.arx_cnt = (arx_idx == LAST) ? '0 : CW'(arx_idx + 1'b1);
				nxt_st.arx_fs = cfg.rxfs_out && (arx_idx == LAST);
				if (arx_idx == LAST)
				begin
					nxt_st.rx_word = arx_next;
					nxt_st.rx_valid = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_ff <= '0;
			st_ff.pins.oe <= ssp_pkg::PIN_OE_RST;
			st_ff.pins.o <= ssp_pkg::PIN_OUT_RST;
		end
		else
			st_ff <= nxt_st;
	end

	assign pin_drive = st_ff.pins;
	assign gpio_in = st_ff.gpio_in;
	assign flag_in = st_ff.flag_in;
	assign tx_ready = st_ff.tx_ready;
	assign rx_word = st_ff.rx_word;
	assign rx_valid = st_ff.rx_valid;

endmodule // ssp_top

/* File: tb/ssp_top_chk.sv */
`timescale 1ns/10ps
module ssp_top_chk (
	// clock and reset
	input clk,
	input reset_n,
	// configuration
	input ssp_pkg::ssp_cfg_t cfg,
	input [5:0] port_ctrl,
	input [5:0] port_dir,
	input stop_mode,
	// data and pins
	input [5:0] gpio_in,
	input tx_valid,
	input tx_ready,
	input rx_valid,
	input ssp_pkg::ssp_pins_t pin_drive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_take;
		tx_valid && tx_ready;
	endsequence
	sequence s_busy;
		!tx_ready [*2];
	endsequence
	property p_rst;
		$rose(reset_n) |-> pin_drive.oe == 6'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("pin driven after reset");
	property p_dir;
		!stop_mode |=> (pin_drive.oe & ~$past(port_ctrl)) == ($past(port_dir) & ~$past(port_ctrl));
	endproperty
	a_dir: assert property (p_dir) else $error("port direction not followed");
	property p_stop;
		stop_mode |=> pin_drive.oe == 6'h00;
	endproperty
	a_stop: assert property (p_stop) else $error("pin driven in stop");
	property p_hold;
		stop_mode |=> $stable(gpio_in);
	endproperty
	a_hold: assert property (p_hold) else $error("input changed in stop");
	property p_rxd;
		port_ctrl[4] |=> !pin_drive.oe[4];
	endproperty
	a_rxd: assert property (p_rxd) else $error("receive data pin driven");
	property p_fs;
		port_ctrl[2] && !stop_mode |=> pin_drive.oe[2] == $past(cfg.fsync_out);
	endproperty
	a_fs: assert property (p_fs) else $error("frame sync direction wrong");
	property p_bclk;
		port_ctrl[3] && !stop_mode |=> pin_drive.oe[3] == $past(cfg.bitclk_out);
	endproperty
	a_bclk: assert property (p_bclk) else $error("bit clock direction wrong");
	property p_ctl0;
		port_ctrl[0] && cfg.async_mode && !stop_mode |=> pin_drive.oe[0] == $past(cfg.rxclk_out);
	endproperty
	a_ctl0: assert property (p_ctl0) else $error("receive clock direction wrong");
	property p_ctl1;
		port_ctrl[1] && cfg.async_mode && !stop_mode |=> pin_drive.oe[1] == $past(cfg.rxfs_out);
	endproperty
	a_ctl1: assert property (p_ctl1) else $error("receive frame direction wrong");
	property p_tx;
		s_take |=> s_busy;
	endproperty
	a_tx: assert property (p_tx) else $error("ready stayed after take");
	property p_rxp;
		rx_valid |=> !rx_valid;
	endproperty
	a_rxp: assert property (p_rxp) else $error("receive valid too long");
endmodule // ssp_top_chk

bind ssp_top ssp_top_chk chk_i (.clk, .reset_n, .cfg, .port_ctrl, .port_dir, .stop_mode,
	.gpio_in, .tx_valid, .tx_ready, .rx_valid, .pin_drive);

/* File: tb/ssp_codec.sv */
`timescale 1ns/10ps
module ssp_codec (
	// bench control
	input run,
	input [15:0] rx_next,
	input [5:0] pin,
	// pins driven
	output logic bclk,
	output logic fs,
	output logic rxd,
	// frame reports
	output logic fst,
	output logic [2:0][15:0] tx_got
);
	logic [3:0] cnt = 4'h0;
	logic [15:0] sh = 16'h0000;
	logic [2:0][15:0] tsh = '0;
	logic [2:0][15:0] got = '0;
	// start values given at declaration so no false edge appears at time zero
	logic clk_r = 1'b0;
	logic fs_r = 1'b0;
	logic rxd_r = 1'b0;
	logic fst_r = 1'b0;
	assign bclk = clk_r;
	assign fs = fs_r;
	assign rxd = rxd_r;
	assign fst = fst_r;
	assign tx_got = got;
	// halves of 8 system cycles; clock rests low when idle
	always #400 if (run || clk_r) clk_r = ~clk_r;
	always @(negedge clk_r)
	begin
		tsh = {tsh[2][14:0], pin[1], tsh[1][14:0], pin[0], tsh[0][14:0], pin[5]};
		// msb stands from the load edge, so a word spans counts 0 to 15
		if (cnt == 4'hF)
			got = tsh;
		if (cnt == 4'h0)
		begin
			sh = rx_next;
			fst_r = ~fst_r;
		end
		fs_r = (cnt == 4'h0);
		rxd_r = sh[4'hF - cnt];
		cnt = cnt + 4'h1;
	end
endmodule // ssp_codec

/* File: tb/ssp_top_test.sv */
`timescale 1ns/10ps
module ssp_top_test;
	logic clk = 0, reset_n = 0, stop_mode = 0, tx_valid = 0, run = 0, prt = 0;
	ssp_pkg::ssp_cfg_t cfg = '0;
	logic [5:0] port_ctrl = 6'h00, port_dir = 6'h00, gpio_out = 6'h00, ext = 6'h00, held;
	logic [2:0][15:0] tx_words = '0;
	logic [15:0] rx_next = 16'h0000;
	wire [5:0] gpio_in, pin_w, src;
	wire [15:0] rx_word;
	wire [1:0] flag_in;
	wire tx_ready, rx_valid, bclk, fs, rxd, fst;
	wire [2:0][15:0] tx_got;
	ssp_pkg::ssp_pins_t pin_drive;
	int errors = 0, n_tests = 0, seed = 32'h9B482F96;
	logic [15:0] rxq[$];
	logic [2:0][15:0] txq[$];
	assign src = prt ? {ext[5], rxd, bclk, fs, ext[1:0]} : ext;
	assign pin_w = (pin_drive.oe & pin_drive.o) | (~pin_drive.oe & src);
	always #25 clk = ~clk;
	ssp_top #(.W(16), .BCLK_HALF(3)) DUT (.clk(clk), .reset_n(reset_n), .link_clk(pin_w[3]),
		.cfg(cfg), .port_ctrl(port_ctrl), .port_dir(port_dir), .stop_mode(stop_mode),
		.gpio_out(gpio_out), .gpio_in(gpio_in), .flag_in(flag_in), .tx_words(tx_words),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
		.pin_in(pin_w), .pin_drive(pin_drive));
	ssp_codec codec (.run(run), .rx_next(rx_next), .pin(pin_w), .bclk(bclk), .fs(fs),
		.rxd(rxd), .fst(fst), .tx_got(tx_got));
	task chk(string nm, logic [47:0] seen, logic [47:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task cyc(int n);
		repeat (n) @(posedge clk);
	endtask
	task send(logic [2:0][15:0] w);
		int i;
		@(posedge clk);
		tx_words <= w;
		tx_valid <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (tx_ready !== 1'b1 && i < 4000);
		if (i >= 4000) errors++;
		if (i >= 4000) report_and_stop;
		txq.push_back(w);
		tx_valid <= 1'b0;
	endtask
	always @(negedge clk)
		if (rx_valid === 1'b1 && rxq.size() > 0) chk("rx_word", rx_word, rxq.pop_front());
	// frame reports count only while the partner's bit clock runs
	always @(fst)
		if (run)
		begin
			rxq.push_back(rx_next);
			rx_next = 16'($random(seed));
			if (tx_got[0] !== 16'h0000 && txq.size() > 0) chk("tx_lanes", tx_got, txq.pop_front());
		end
	initial
	begin
		cyc(12);
		reset_n <= 1'b1;
		ext <= 6'($random(seed));
		cyc(6);
		chk("reset_oe", pin_drive.oe, 6'h00);
		chk("reset_in", gpio_in, ext);
		repeat (4)
		begin
			port_dir <= 6'($random(seed));
			gpio_out <= 6'($random(seed));
			ext <= 6'($random(seed));
			cyc(5);
			chk("gpio_oe", pin_drive.oe, port_dir);
			chk("gpio_pin", pin_w, (gpio_out & port_dir) | (ext & ~port_dir));
			chk("gpio_in", gpio_in, pin_w);
		end
		$display("test gpio finished");
		stop_mode <= 1'b1;
		port_dir <= 6'h3F;
		cyc(3);
		held = gpio_in;
		ext <= ~ext;
		cyc(5);
		chk("stop_oe", pin_drive.oe, 6'h00);
		chk("stop_in", gpio_in, held);
		stop_mode <= 1'b0;
		$display("test stop finished");
		cfg <= '{async_mode: 1'b1, rxclk_out: 1'b1, rxfs_out: 1'b1, rx_en: 1'b1, default: '0};
		port_ctrl <= 6'h3F;
		// receive data pin rests at one level, so the first word is that level throughout
		rxq.push_back({16{ext[4]}});
		cyc(120);
		chk("async_oe", pin_drive.oe[1:0], 2'h3);
		$display("test async finished");
		cfg <= '{tx_en: 1'b1, rx_en: 1'b1, default: '0};
		prt <= 1'b1;
		run <= 1'b1;
		repeat (3) send({16'($random(seed)), 16'($random(seed)), 16'($random(seed)) | 16'h0001});
		cyc(1500);
		chk("tx_left", txq.size(), 0);
		run <= 1'b0;
		$display("test sync finished");
		prt <= 1'b0;
		cfg <= '{bitclk_out: 1'b1, fsync_out: 1'b1, flag_mode: 1'b1, flag_is_out: 2'h1,
			flag_out: 2'($random(seed)), default: '0};
		cyc(8);
		chk("ctl_oe", pin_drive.oe[3:0], 4'hD);
		chk("flag_in", flag_in, {ext[1], cfg.flag_out[0]});
		$display("test flag finished");
		report_and_stop;
	end
endmodule // ssp_top_test
